// ==== rtl/ofd_decoder.sv ====
// Module: operand field decoder with PC-relative and scaled effective address forming
// What this block does
// - Short PC-relative: sign-extend 8-bit displacement, double, add to PC.
// - Long PC-relative: sign-extend 12-bit displacement, double, add to PC.
// - Register PC-relative: PC plus full source register, unscaled.
// - 8-bit immediate zero-extended for test, AND, OR, exclusive-OR.
// - 8-bit immediate sign-extended for move, add, compare-equal.
// - Trap: zero-extend 8-bit immediate, multiply by four.
// - Meaning of each operand field follows the opcode bits.
// - Bits 11:8 destination, 7:4 source, low bits displacement or immediate.
// - Control loads from direct or post-increment; stores to direct or pre-decrement.
// - Multiply-accumulate: destination field is second post-increment source.
// - 4-bit register displacement zero-extended, scaled 1, 2 or 4.
// - Global-base displacement zero-extended, scaled by size, added to base.
module ofd_decoder (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    input wire logic [15:0] instr,
    input wire logic [31:0] fetch_pc,
    input wire logic [31:0] src_value,
    input wire logic [31:0] dest_value,
    input wire logic [31:0] global_base_register,
    input wire logic out_ready,
    output logic in_ready,
    output logic [3:0] src_sel,
    output logic [3:0] dest_sel,
    output logic out_valid,
    output ofd_pkg::ofd_dec_t out_dec
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] sext8x2(input logic [7:0] d);
        sext8x2 = {{23{d[7]}}, d, 1'b0};
    endfunction : sext8x2

    function automatic logic [31:0] zscale(input logic [7:0] d, input logic [1:0] sz);
        logic [31:0] z;
        z = {24'h000000, d};
        unique case (sz)
            ofd_pkg::OFD_SZ_BYTE: zscale = z;
            ofd_pkg::OFD_SZ_WORD: zscale = {z[30:0], 1'b0};
            default: zscale = {z[29:0], 2'b00};
        endcase
    endfunction : zscale

    function automatic ofd_pkg::ofd_class_t classify(input logic [15:0] w);
        logic [3:0] sub;
        sub = w[ofd_pkg::OFD_DST_HI:ofd_pkg::OFD_DST_LO];
        classify = ofd_pkg::OFD_CL_NONE;
        unique case (w[ofd_pkg::OFD_OP_HI:ofd_pkg::OFD_OP_LO])
            ofd_pkg::OFD_OP_SYS:
            begin
                unique case (w[3:0])
                    ofd_pkg::OFD_SYS_BRANCH_FAR_REGISTER_INSTR: classify = ofd_pkg::OFD_CL_BRANCH_FAR_REGISTER_INSTR;
                    ofd_pkg::OFD_SYS_CTRL_LD: classify = ofd_pkg::OFD_CL_CTRL_LD;
                    ofd_pkg::OFD_SYS_CTRL_LD_INC: classify = ofd_pkg::OFD_CL_CTRL_LD_INC;
                    ofd_pkg::OFD_SYS_CTRL_ST: classify = ofd_pkg::OFD_CL_CTRL_ST;
                    ofd_pkg::OFD_SYS_CTRL_ST_DEC: classify = ofd_pkg::OFD_CL_CTRL_ST_DEC;
                    ofd_pkg::OFD_SYS_MAC: classify = ofd_pkg::OFD_CL_MAC;
                    default: classify = ofd_pkg::OFD_CL_NONE;
                endcase
            end
            ofd_pkg::OFD_OP_DISP_LONG: classify = ofd_pkg::OFD_CL_DISP_LD;
            ofd_pkg::OFD_OP_REG_REG: classify = ofd_pkg::OFD_CL_REG_REG;
            ofd_pkg::OFD_OP_ADD_IMM: classify = ofd_pkg::OFD_CL_IMM_ARITH;
            ofd_pkg::OFD_OP_MOV_IMM: classify = ofd_pkg::OFD_CL_IMM_ARITH;
            ofd_pkg::OFD_OP_PC_LOAD: classify = ofd_pkg::OFD_CL_PC_LOAD;
            ofd_pkg::OFD_OP_BR_ALWAYS: classify = ofd_pkg::OFD_CL_BR_ALWAYS;
            ofd_pkg::OFD_OP_SHORT:
            begin
                if (sub <= ofd_pkg::OFD_SH_DISP_LD_MAX)
                    classify = ofd_pkg::OFD_CL_DISP_LD;
                else if (sub == ofd_pkg::OFD_SH_DISP_ST)
                    classify = ofd_pkg::OFD_CL_DISP_ST;
                else if (sub >= ofd_pkg::OFD_SH_GBR_LO && sub <= ofd_pkg::OFD_SH_GBR_HI)
                    classify = ofd_pkg::OFD_CL_GBR_LD;
                else if (sub == ofd_pkg::OFD_SH_MOVEA)
                    classify = ofd_pkg::OFD_CL_MOVEA;
                else if (sub == ofd_pkg::OFD_SH_BR_FALSE)
                    classify = ofd_pkg::OFD_CL_BR_FALSE;
                else if (sub >= ofd_pkg::OFD_SH_LOGIC_LO && sub <= ofd_pkg::OFD_SH_LOGIC_HI)
                    classify = ofd_pkg::OFD_CL_IMM_LOGIC;
                else if (sub == ofd_pkg::OFD_SH_TRAP)
                    classify = ofd_pkg::OFD_CL_TRAP;
                else if (sub == ofd_pkg::OFD_SH_COMPARE_EQUAL_INSTR)
                    classify = ofd_pkg::OFD_CL_IMM_ARITH;
                else
                    classify = ofd_pkg::OFD_CL_NONE;
            end
            default: classify = ofd_pkg::OFD_CL_NONE;
        endcase
    endfunction : classify

    // ****************************************
    // Decode
    // ****************************************
    ofd_pkg::ofd_class_t cls;
    ofd_pkg::ofd_dec_t next_dec;
    logic take;

    // Register file is read off the raw fields so values arrive in the same cycle
    assign src_sel = instr[ofd_pkg::OFD_SRC_HI:ofd_pkg::OFD_SRC_LO];
    assign dest_sel = instr[ofd_pkg::OFD_DST_HI:ofd_pkg::OFD_DST_LO];
    assign cls = classify(instr);
    assign in_ready = ~out_valid | out_ready;
    assign take = clk_en & in_valid & in_ready;

    always_comb
    begin
        next_dec = '0;
        next_dec.cls = cls;
        next_dec.dst_idx = dest_sel;
        next_dec.src_idx = src_sel;
        unique case (cls)
            ofd_pkg::OFD_CL_BRANCH_FAR_REGISTER_INSTR:
            begin
                next_dec.src_idx = dest_sel;
                next_dec.ea = fetch_pc + dest_value;
                next_dec.ea_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_CTRL_LD, ofd_pkg::OFD_CL_CTRL_LD_INC:
            begin
                // Source field sits in 11:8 for this group
                next_dec.src_idx = dest_sel;
                next_dec.src_postinc = (cls == ofd_pkg::OFD_CL_CTRL_LD_INC);
                next_dec.ctrl_load = 1'b1;
            end
            ofd_pkg::OFD_CL_CTRL_ST, ofd_pkg::OFD_CL_CTRL_ST_DEC:
            begin
                next_dec.dst_predec = (cls == ofd_pkg::OFD_CL_CTRL_ST_DEC);
                next_dec.ctrl_store = 1'b1;
            end
            ofd_pkg::OFD_CL_MAC:
            begin
                next_dec.src_postinc = 1'b1;
                next_dec.dst_is_src = 1'b1;
            end
            ofd_pkg::OFD_CL_DISP_LD:
            begin
                if (instr[15:12] == ofd_pkg::OFD_OP_DISP_LONG)
                    next_dec.ea = src_value + zscale({4'h0, instr[3:0]}, ofd_pkg::OFD_SZ_LONG);
                else
                    next_dec.ea = src_value + zscale({4'h0, instr[3:0]}, instr[9:8]);
                next_dec.ea_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_DISP_ST:
            begin
                next_dec.dst_idx = src_sel;
                next_dec.ea = src_value + zscale({4'h0, instr[3:0]}, ofd_pkg::OFD_SZ_BYTE);
                next_dec.ea_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_GBR_LD:
            begin
                next_dec.ea = global_base_register + zscale(instr[7:0], instr[9:8]);
                next_dec.ea_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_MOVEA, ofd_pkg::OFD_CL_BR_FALSE, ofd_pkg::OFD_CL_PC_LOAD:
            begin
                // Same PC source as the long branch keeps data loads and jumps aligned
                next_dec.ea = fetch_pc + sext8x2(instr[7:0]);
                next_dec.ea_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_BR_ALWAYS:
            begin
                next_dec.ea = fetch_pc + {{19{instr[11]}}, instr[11:0], 1'b0};
                next_dec.ea_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_IMM_LOGIC:
            begin
                next_dec.imm = {24'h000000, instr[7:0]};
                next_dec.imm_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_IMM_ARITH:
            begin
                next_dec.imm = {{24{instr[7]}}, instr[7:0]};
                next_dec.imm_ok = 1'b1;
            end
            ofd_pkg::OFD_CL_TRAP:
            begin
                next_dec.imm = {22'h000000, instr[7:0], 2'b00};
                next_dec.imm_ok = 1'b1;
            end
            default:
            begin
                next_dec.ea = '0;
            end
        endcase
    end

    // ****************************************
    // Output stage
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            out_valid <= ofd_pkg::OFD_VALID_RST;
        else if (clk_en && in_ready)
            out_valid <= in_valid;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            out_dec <= '0;
        else if (take)
            out_dec <= next_dec;
    end

    // ****************************************
    // Checks
    // ****************************************
    logic loaded;
    logic [15:0] cap_instr;
    logic [31:0] cap_pc;
    logic [31:0] cap_src;
    logic [31:0] cap_dst;
    logic [31:0] cap_gbr;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded <= 1'b0;
            cap_instr <= 16'h0000;
            cap_pc <= 32'h00000000;
            cap_src <= 32'h00000000;
            cap_dst <= 32'h00000000;
            cap_gbr <= 32'h00000000;
        end
        else
        begin
            // Gated like the output stage so checks see frozen state too
            if (clk_en)
                loaded <= take;
            if (take)
            begin
                cap_instr <= instr;
                cap_pc <= fetch_pc;
                cap_src <= src_value;
                cap_dst <= dest_value;
                cap_gbr <= global_base_register;
            end
        end
    end

    sequence s_stalled;
        out_valid && !out_ready && clk_en;
    endsequence

    sequence s_held;
        out_valid && $stable(out_dec);
    endsequence

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        s_stalled |=> s_held;
    endproperty

    a_output_hold: assert property (p_hold) else $error("decoded operand changed under stall");
    a_short_pc_ea: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && out_dec.cls == ofd_pkg::OFD_CL_BR_FALSE |-> out_dec.ea ==
        cap_pc + {{23{cap_instr[7]}}, cap_instr[7:0], 1'b0})
        else $error("short PC-relative address wrong");
    a_long_pc_ea: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && cap_instr[15:12] == 4'hA |-> out_dec.ea_ok &&
        out_dec.ea == cap_pc + {{19{cap_instr[11]}}, cap_instr[11:0], 1'b0})
        else $error("long PC-relative address wrong");
    a_reg_pc_ea: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && out_dec.cls == ofd_pkg::OFD_CL_BRANCH_FAR_REGISTER_INSTR |-> out_dec.ea == cap_pc + cap_dst)
        else $error("register PC-relative address wrong");
    a_logic_imm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && out_dec.cls == ofd_pkg::OFD_CL_IMM_LOGIC |-> out_dec.imm_ok &&
        out_dec.imm == {24'h000000, cap_instr[7:0]})
        else $error("logical immediate not zero-extended");
    a_arith_imm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && out_dec.cls == ofd_pkg::OFD_CL_IMM_ARITH |->
        out_dec.imm == {{24{cap_instr[7]}}, cap_instr[7:0]})
        else $error("arithmetic immediate not sign-extended");
    a_trap_offset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && out_dec.cls == ofd_pkg::OFD_CL_TRAP |-> out_dec.imm == 32'(cap_instr[7:0]) * 4)
        else $error("trap offset wrong");
    a_gbr_ea: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && out_dec.cls == ofd_pkg::OFD_CL_GBR_LD && cap_instr[9:8] == 2'h2 |->
        out_dec.ea == cap_gbr + 32'(cap_instr[7:0]) * 4)
        else $error("global-base address wrong");
    a_mac_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loaded && out_dec.cls == ofd_pkg::OFD_CL_MAC |->
        out_dec.dst_is_src && out_dec.src_postinc && out_dec.dst_idx == cap_instr[11:8])
        else $error("multiply-accumulate fields wrong");
    a_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !clk_en |=> $stable(out_valid) && $stable(out_dec))
        else $error("state moved while clock enable low");

endmodule : ofd_decoder

// ==== shared/ofd_pkg.sv ====
// Package: opcode map, operand classes and decoded-operand carrier for the operand decoder
package ofd_pkg;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int OFD_OP_HI = 15;
    localparam int OFD_OP_LO = 12;
    localparam int OFD_DST_HI = 11;
    localparam int OFD_DST_LO = 8;
    localparam int OFD_SRC_HI = 7;
    localparam int OFD_SRC_LO = 4;

    // ****************************************
    // Opcode map, bits 15:12
    // ****************************************
    localparam logic [3:0] OFD_OP_SYS = 4'h0;
    localparam logic [3:0] OFD_OP_DISP_LONG = 4'h1;
    localparam logic [3:0] OFD_OP_REG_REG = 4'h2;
    localparam logic [3:0] OFD_OP_ADD_IMM = 4'h7;
    localparam logic [3:0] OFD_OP_SHORT = 4'h8;
    localparam logic [3:0] OFD_OP_PC_LOAD = 4'h9;
    localparam logic [3:0] OFD_OP_BR_ALWAYS = 4'hA;
    localparam logic [3:0] OFD_OP_MOV_IMM = 4'hE;

    // System group, selected by bits 3:0
    localparam logic [3:0] OFD_SYS_BRANCH_FAR_REGISTER_INSTR = 4'h3;
    localparam logic [3:0] OFD_SYS_CTRL_LD = 4'h4;
    localparam logic [3:0] OFD_SYS_CTRL_LD_INC = 4'h5;
    localparam logic [3:0] OFD_SYS_CTRL_ST = 4'h6;
    localparam logic [3:0] OFD_SYS_CTRL_ST_DEC = 4'h7;
    localparam logic [3:0] OFD_SYS_MAC = 4'hF;

    // Short group, selected by bits 11:8
    localparam logic [3:0] OFD_SH_DISP_LD_MAX = 4'h2;
    localparam logic [3:0] OFD_SH_DISP_ST = 4'h3;
    localparam logic [3:0] OFD_SH_GBR_LO = 4'h4;
    localparam logic [3:0] OFD_SH_GBR_HI = 4'h6;
    localparam logic [3:0] OFD_SH_MOVEA = 4'h7;
    localparam logic [3:0] OFD_SH_BR_FALSE = 4'h8;
    localparam logic [3:0] OFD_SH_LOGIC_LO = 4'h9;
    localparam logic [3:0] OFD_SH_LOGIC_HI = 4'hC;
    localparam logic [3:0] OFD_SH_TRAP = 4'hD;
    localparam logic [3:0] OFD_SH_COMPARE_EQUAL_INSTR = 4'hE;

    // Access size codes
    localparam logic [1:0] OFD_SZ_BYTE = 2'h0;
    localparam logic [1:0] OFD_SZ_WORD = 2'h1;
    localparam logic [1:0] OFD_SZ_LONG = 2'h2;

    // Reset values
    localparam logic OFD_VALID_RST = 1'b0;

    typedef enum logic [4:0] {
        OFD_CL_NONE,
        OFD_CL_CTRL_LD,
        OFD_CL_CTRL_LD_INC,
        OFD_CL_CTRL_ST,
        OFD_CL_CTRL_ST_DEC,
        OFD_CL_BRANCH_FAR_REGISTER_INSTR,
        OFD_CL_MAC,
        OFD_CL_REG_REG,
        OFD_CL_DISP_LD,
        OFD_CL_DISP_ST,
        OFD_CL_GBR_LD,
        OFD_CL_MOVEA,
        OFD_CL_BR_FALSE,
        OFD_CL_BR_ALWAYS,
        OFD_CL_PC_LOAD,
        OFD_CL_IMM_LOGIC,
        OFD_CL_IMM_ARITH,
        OFD_CL_TRAP
    } ofd_class_t;

    typedef struct packed {
        ofd_class_t cls;
        logic [3:0] dst_idx;
        logic [3:0] src_idx;
        logic [31:0] ea;
        logic [31:0] imm;
        logic ea_ok;
        logic imm_ok;
        logic src_postinc;
        logic dst_predec;
        logic dst_is_src;
        logic ctrl_load;
        logic ctrl_store;
    } ofd_dec_t;

endpackage : ofd_pkg

// ==== test/ofd_decoder_tb_top.sv ====
// Bench: self-checking testbench for the operand field decoder
module ofd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Stimulus and observation
    // ****************************************
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic in_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [31:0] fetch_pc = 32'h0000_0000;
    logic [31:0] src_value = 32'h0000_0000;
    logic [31:0] dest_value = 32'h0000_0000;
    logic [31:0] global_base_register = 32'h0000_0000;
    logic out_ready = 1'b1;
    logic in_ready;
    logic [3:0] src_sel;
    logic [3:0] dest_sel;
    logic out_valid;
    ofd_pkg::ofd_dec_t out_dec;
    ofd_pkg::ofd_dec_t res;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    ofd_decoder u_dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(in_valid),
        .instr(instr),
        .fetch_pc(fetch_pc),
        .src_value(src_value),
        .dest_value(dest_value),
        .global_base_register(global_base_register),
        .out_ready(out_ready),
        .in_ready(in_ready),
        .src_sel(src_sel),
        .dest_sel(dest_sel),
        .out_valid(out_valid),
        .out_dec(out_dec)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [31:0] sx2(input logic [11:0] d, input int w);
        logic [31:0] v;
        v = (w == 8) ? {{24{d[7]}}, d[7:0]} : {{20{d[11]}}, d};
        return v << 1;
    endfunction : sx2

    // One accepted request; consumer is always ready here
    task automatic decode(input logic [15:0] w);
        @(posedge clk_sys);
        in_valid <= 1'b1;
        instr <= w;
        @(posedge clk_sys);
        in_valid <= 1'b0;
        #1;
        check(32'(out_valid), 32'h1);
        res = out_dec;
    endtask : decode

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pc_rel;
        fetch_pc <= 32'h0001_0000;
        dest_value <= 32'hFFFF_FF00;
        decode(16'h8880);
        check(res.ea, 32'h0001_0000 + sx2(12'h080, 8));
        decode(16'h937F);
        check(res.ea, 32'h0001_0000 + sx2(12'h07F, 8));
        decode(16'h87FE);
        check(res.ea, 32'h0001_0000 + sx2(12'h0FE, 8));
        decode(16'hA800);
        check(res.ea, 32'h0001_0000 + sx2(12'h800, 12));
        check(32'(res.cls), 32'(ofd_pkg::OFD_CL_BR_ALWAYS));
        decode(16'h0503);
        check(res.ea, 32'h0000_FF00);
        check(32'({res.src_idx, res.ea_ok, res.imm_ok}), 32'h0000_0016);
        $display("test pc_rel done");
    endtask : t_pc_rel

    task automatic t_imm;
        logic [3:0] op [3] = '{4'h7, 4'hE, 4'h8};
        for (int s = 9; s <= 12; s++)
        begin
            decode({4'h8, 4'(s), 8'h80});
            check(res.imm, 32'h0000_0080);
        end
        for (int k = 0; k < 3; k++)
        begin
            decode({op[k], (k == 2) ? 4'hE : 4'h3, 8'h80});
            check(res.imm, 32'hFFFF_FF80);
        end
        decode(16'h8DFF);
        check(res.imm, 32'h0000_03FC);
        check(32'(res.cls), 32'(ofd_pkg::OFD_CL_TRAP));
        check(32'({res.ea_ok, res.imm_ok}), 32'h0000_0001);
        decode(16'h3123);
        check(32'(res.cls), 32'(ofd_pkg::OFD_CL_NONE));
        check(32'({res.ea_ok, res.imm_ok}), 32'h0000_0000);
        $display("test imm done");
    endtask : t_imm

    task automatic t_disp;
        @(posedge clk_sys);
        src_value <= 32'h2000_0000;
        global_base_register <= 32'h4000_0000;
        for (int s = 0; s < 3; s++)
        begin
            decode({4'h8, 2'b00, 2'(s), 8'h6F});
            check(res.ea, 32'h2000_0000 + (32'h0000_000F << s));
            decode({4'h8, 2'b01, 2'(s), 8'hFF});
            check(res.ea, 32'h4000_0000 + (32'h0000_00FF << s));
        end
        decode(16'h126F);
        check(res.ea, 32'h2000_003C);
        decode(16'h836A);
        check(res.ea, 32'h2000_000A);
        check(32'(res.dst_idx), 32'h0000_0006);
        $display("test disp done");
    endtask : t_disp

    task automatic t_ctrl;
        logic [3:0] sub [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
        logic [4:0] exp [5] = '{5'h10, 5'h14, 5'h08, 5'h0A, 5'h05};
        for (int k = 0; k < 5; k++)
        begin
            decode({8'h03, 4'h0, sub[k]});
            check(32'({res.ctrl_load, res.ctrl_store, res.src_postinc, res.dst_predec,
                       res.dst_is_src}), 32'(exp[k]));
        end
        check(32'(res.cls), 32'(ofd_pkg::OFD_CL_MAC));
        $display("test ctrl done");
    endtask : t_ctrl

    // Field split plus hold under back-pressure and clock-enable freeze
    task automatic t_fields;
        @(posedge clk_sys);
        instr <= 16'h2A50;
        in_valid <= 1'b1;
        out_ready <= 1'b0;
        #1;
        check(32'({dest_sel, src_sel}), 32'h0000_00A5);
        @(posedge clk_sys);
        instr <= 16'h2370;
        #1;
        check(32'({in_ready, out_valid}), 32'h1);
        check(32'({out_dec.dst_idx, out_dec.src_idx}), 32'h0000_00A5);
        repeat (3) @(posedge clk_sys);
        #1;
        check(32'({out_dec.dst_idx, out_dec.src_idx}), 32'h0000_00A5);
        check(32'(out_dec.cls), 32'(ofd_pkg::OFD_CL_REG_REG));
        @(posedge clk_sys);
        out_ready <= 1'b1;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        instr <= 16'h2BC0;
        #1;
        check(32'({out_dec.dst_idx, out_dec.src_idx}), 32'h0000_0037);
        repeat (2) @(posedge clk_sys);
        #1;
        check(32'({out_valid, out_dec.dst_idx, out_dec.src_idx}), 32'h0000_0137);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        in_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check(32'(out_valid), 32'h0);
        check(32'({out_dec.dst_idx, out_dec.src_idx}), 32'h0000_0037);
        $display("test fields done");
    endtask : t_fields

    // ****************************************
    // Sequence and watchdog
    // ****************************************
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            bad_count++;
            conclude();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_pc_rel();
        t_imm();
        t_disp();
        t_ctrl();
        t_fields();
        conclude();
    end

endmodule : ofd_decoder_tb_top
